/* hw/etc_top.sv */
// exposure and trigger control: APB registers, exposure conversion, frame sequencer
//
// The register addresses and the APB register port were decided locally.
`timescale 1ns/1ns
`default_nettype none
module etc_top import etc_pkg::*; #(
	parameter int READOUT_CYCLES = ETC_READOUT_US * ETC_TICK_CYCLES,
	parameter int XMIT_CYCLES    = ETC_XMIT_US * ETC_TICK_CYCLES
) (
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic        psel_i,
	input  wire logic        penable_i,
	input  wire logic        pwrite_i,
	input  wire logic [7:0]  paddr_i,
	input  wire logic [31:0] pwdata_i,
	output logic [31:0]      prdata_o,
	output logic             pready_o,
	output logic             pslverr_o,
	input  wire logic        line1_i,
	output logic             exposing_o,
	output logic             readout_o,
	output logic             xmit_o,
	output logic             frame_start_o
);
	// ****************************************
	// registers
	// ****************************************
	etc_ctrl_t   ctrl;
	etc_timing_t tim;
	logic [31:0] exp_abs;
	logic [31:0] frames;
	etc_state_t  state;
	etc_state_t  next_state;

	logic        conv_busy;
	logic        conv_done;
	logic [11:0] conv_raw;
	logic        line_lvl;
	logic        line_rise;
	// read data is loaded one edge before pready, so a stalled read sees fresh values
	logic        rd_ok;

	// ****************************************
	// bus decode
	// ****************************************
	// writes during a conversion wait so abs and raw never disagree
	wire access    = psel_i & penable_i;
	wire hit_ctrl  = paddr_i == ETC_OFF_CTRL;
	wire hit_abs   = paddr_i == ETC_OFF_EXP_ABS;
	wire hit_raw   = paddr_i == ETC_OFF_EXP_RAW;
	wire hit_base  = paddr_i == ETC_OFF_BASE;
	wire hit_per   = paddr_i == ETC_OFF_PERIOD;
	wire hit_stat  = paddr_i == ETC_OFF_STATUS;
	wire hit_frm   = paddr_i == ETC_OFF_FRAMES;
	wire mapped    = hit_ctrl | hit_abs | hit_raw | hit_base | hit_per | hit_stat | hit_frm;
	wire bus_stall = conv_busy | conv_done;
	wire wr        = access & pwrite_i & ~bus_stall;
	wire wr_abs    = wr & hit_abs;
	wire wr_raw    = wr & hit_raw;
	wire wr_base   = wr & hit_base;
	wire [11:0] raw_wr = (pwdata_i[11:0] == 12'h0) ? ETC_RAW_MIN : pwdata_i[11:0];
	// abs readback: raw times base
	wire [35:0] abs_calc  = {24'h0, tim.raw} * {12'h0, tim.base};
	wire [35:0] abs_conv  = {24'h0, conv_raw} * {12'h0, tim.base};
	wire [31:0] ctrl_word = {27'h0, ctrl.rate_en, ctrl.fs_trig, ctrl.as_trig,
	                         ctrl.acq_en, ctrl.standard};
	wire [31:0] stat_word = {27'h0, line_lvl, conv_busy, state};

	assign pready_o  = ~bus_stall & (pwrite_i | rd_ok);
	assign pslverr_o = access & pready_o & ~mapped;

	// ****************************************
	// register writes
	// ****************************************
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ctrl       <= '0;
			tim.raw    <= ETC_RAW_RST;
			tim.base   <= ETC_BASE_RST;
			tim.period <= ETC_PERIOD_RST;
			exp_abs    <= 32'(ETC_RAW_RST) * 32'(ETC_BASE_RST);
		end else begin
			if (wr & hit_ctrl) begin
				ctrl.standard <= pwdata_i[ETC_CTRL_STANDARD];
				ctrl.acq_en   <= pwdata_i[ETC_CTRL_ACQ_EN];
				ctrl.as_trig  <= pwdata_i[ETC_CTRL_AS_TRIG];
				ctrl.fs_trig  <= pwdata_i[ETC_CTRL_FS_TRIG];
				ctrl.rate_en  <= pwdata_i[ETC_CTRL_RATE_EN];
			end
			if (wr & hit_per)
				tim.period <= pwdata_i;
			if (wr_abs)
				exp_abs <= pwdata_i;
			if (wr_raw) begin
				tim.raw <= raw_wr;
				exp_abs <= 32'({24'h0, raw_wr} * {12'h0, tim.base});
			end
			if (wr_base) begin
				tim.base <= pwdata_i[23:0];
				exp_abs  <= 32'({24'h0, tim.raw} * {12'h0, pwdata_i[23:0]});
			end
			if (conv_done) begin
				tim.raw <= conv_raw;
				exp_abs <= abs_conv[31:0];
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i)
			rd_ok <= 1'b0;
		else
			rd_ok <= psel_i & ~pwrite_i & ~bus_stall & ~(access & pready_o);
	end

	always_ff @(posedge clk_i) begin
		if (rst_i)
			prdata_o <= 32'h0;
		else if (psel_i & ~pwrite_i & ~bus_stall)
			prdata_o <= hit_ctrl ? ctrl_word :
			            hit_abs  ? exp_abs :
			            hit_raw  ? {20'h0, tim.raw} :
			            hit_base ? {8'h0, tim.base} :
			            hit_per  ? tim.period :
			            hit_stat ? stat_word :
			            hit_frm  ? frames : ETC_UNMAPPED;
	end

	etc_exp_conv u_conv (
		.clk_i   (clk_i),
		.rst_i   (rst_i),
		.start_i (wr_abs),
		.abs_i   (pwdata_i),
		.base_i  (tim.base),
		.busy_o  (conv_busy),
		.done_o  (conv_done),
		.raw_o   (conv_raw)
	);

	etc_edge_sync u_line1 (
		.clk_i   (clk_i),
		.rst_i   (rst_i),
		.pin_i   (line1_i),
		.level_o (line_lvl),
		.rise_o  (line_rise)
	);

	// ****************************************
	// timebase and frame pacing
	// ****************************************
	logic [7:0]  tick_cnt;
	logic [31:0] period_cnt;
	logic [11:0] exp_cnt;
	logic [23:0] base_cnt;
	logic [31:0] phase_cnt;

	wire tick = tick_cnt == 8'(ETC_TICK_CYCLES - 1);
	// in legacy mode the acquisition-start stage is absent
	wire as_needed  = ctrl.standard & ctrl.as_trig;
	// legacy: the single trigger is the frame trigger under its old name
	wire fs_ext     = ctrl.fs_trig;
	// the tick term lets the start land exactly one period after the last one
	wire pace_ok    = ~ctrl.rate_en | (period_cnt >= tim.period) |
	                  (tick & (33'(period_cnt) + 33'h1 >= 33'(tim.period)));
	wire int_start  = ~fs_ext & pace_ok;
	wire ext_start  = fs_ext & line_rise;
	wire go         = ctrl.acq_en & ~as_needed;
	wire start_now  = (state == ETC_WAIT_FS) & (int_start | ext_start);
	wire base_wrap  = tick & (base_cnt >= tim.base - 24'h1);
	wire exp_end    = base_wrap & (exp_cnt >= tim.raw - 12'h1);
	wire phase_end  = phase_cnt >= ((state == ETC_READOUT) ? 32'(READOUT_CYCLES - 1) :
	                                                         32'(XMIT_CYCLES - 1));

	always_comb begin
		next_state = state;
		case (state)
			ETC_IDLE:    if (go) next_state = ETC_WAIT_FS;
			ETC_WAIT_FS: begin
				if (!go)
					next_state = ETC_IDLE;
				else if (start_now)
					next_state = ETC_EXPOSE;
			end
			ETC_EXPOSE:  if (exp_end) next_state = ETC_READOUT;
			ETC_READOUT: if (phase_end) next_state = ETC_XMIT;
			ETC_XMIT:    if (phase_end) next_state = ETC_WAIT_FS;
			default:     next_state = ETC_IDLE;
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state    <= ETC_IDLE;
			tick_cnt <= 8'h0;
		end else begin
			state    <= next_state;
			tick_cnt <= (tick | start_now) ? 8'h0 : tick_cnt + 8'h1;
		end
	end

	// period counted in microseconds from each frame start
	always_ff @(posedge clk_i) begin
		if (rst_i)
			period_cnt <= 32'h0;
		else if (start_now)
			period_cnt <= 32'h0;
		else if (tick && period_cnt != 32'hFFFFFFFF)
			period_cnt <= period_cnt + 32'h1;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i || start_now) begin
			exp_cnt  <= 12'h0;
			base_cnt <= 24'h0;
		end else if (state == ETC_EXPOSE && tick) begin
			base_cnt <= base_wrap ? 24'h0 : base_cnt + 24'h1;
			if (base_wrap)
				exp_cnt <= exp_cnt + 12'h1;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i || state != next_state)
			phase_cnt <= 32'h0;
		else
			phase_cnt <= phase_cnt + 32'h1;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			frames        <= 32'h0;
			frame_start_o <= 1'b0;
			exposing_o    <= 1'b0;
			readout_o     <= 1'b0;
			xmit_o        <= 1'b0;
		end else begin
			frame_start_o <= start_now;
			if (start_now)
				frames <= frames + 32'h1;
			exposing_o <= next_state == ETC_EXPOSE;
			readout_o  <= next_state == ETC_READOUT;
			xmit_o     <= next_state == ETC_XMIT;
		end
	end
endmodule
`default_nettype wire

/* pkg/etc_pkg.sv */
// package: register map, field layout, timing constants and types for exposure trigger control
// Operation
// - exposure set in whole microseconds
// - absolute write derives stored raw multiplier
// - inexact absolute snaps to nearest multiple
// - raw write recomputes absolute readback
// - legacy mode: no acquisition-start stage
// - reset selects legacy mode
// - free run: all starts generated internally
// - free run paced by frame rate period
// - rate control off: back-to-back frames
// - acquisition-start off: generated internally
// - rising edge on line one starts exposure
// - each accepted edge gives one frame
// - exposure = raw times base, raw 1..4095
package etc_pkg;

	// ****************************************
	// register offsets
	// ****************************************
	localparam logic [7:0] ETC_OFF_CTRL     = 8'h00;
	localparam logic [7:0] ETC_OFF_EXP_ABS  = 8'h04;
	localparam logic [7:0] ETC_OFF_EXP_RAW  = 8'h08;
	localparam logic [7:0] ETC_OFF_BASE     = 8'h0C;
	localparam logic [7:0] ETC_OFF_PERIOD   = 8'h10;
	localparam logic [7:0] ETC_OFF_STATUS   = 8'h14;
	localparam logic [7:0] ETC_OFF_FRAMES   = 8'h18;

	// ****************************************
	// control field positions
	// ****************************************
	localparam int ETC_CTRL_STANDARD = 0;
	localparam int ETC_CTRL_ACQ_EN   = 1;
	localparam int ETC_CTRL_AS_TRIG  = 2;
	localparam int ETC_CTRL_FS_TRIG  = 3;
	localparam int ETC_CTRL_RATE_EN  = 4;

	// ****************************************
	// reset values and limits
	// ****************************************
	localparam logic [11:0] ETC_RAW_MIN   = 12'h001;
	localparam logic [11:0] ETC_RAW_MAX   = 12'hFFF;
	localparam logic [11:0] ETC_RAW_RST   = 12'h064;
	localparam logic [23:0] ETC_BASE_RST  = 24'h000014;
	localparam logic [31:0] ETC_PERIOD_RST = 32'h000003E8;
	localparam logic [31:0] ETC_UNMAPPED  = 32'h00000000;

	// ****************************************
	// timing
	// ****************************************
	localparam int ETC_CLK_HZ      = 10_000_000;
	localparam int ETC_TICK_US     = 1;
	localparam int ETC_TICK_CYCLES = ETC_CLK_HZ / 1_000_000 * ETC_TICK_US;
	localparam int ETC_READOUT_US  = 50;
	localparam int ETC_XMIT_US     = 50;

	typedef enum logic [2:0] {
		ETC_IDLE    = 3'b000,
		ETC_WAIT_FS = 3'b001,
		ETC_EXPOSE  = 3'b010,
		ETC_READOUT = 3'b011,
		ETC_XMIT    = 3'b100
	} etc_state_t;

	typedef struct packed {
		logic standard;
		logic acq_en;
		logic as_trig;
		logic fs_trig;
		logic rate_en;
	} etc_ctrl_t;

	typedef struct packed {
		logic [11:0] raw;
		logic [23:0] base;
		logic [31:0] period;
	} etc_timing_t;

endpackage

/* hw/etc_edge_sync.sv */
// two-flop synchroniser and rising-edge detector for an input pin
`timescale 1ns/1ns
`default_nettype none
module etc_edge_sync import etc_pkg::*; (
	input  wire logic clk_i,
	input  wire logic rst_i,
	input  wire logic pin_i,
	output logic      level_o,
	output logic      rise_o
);
	logic meta;
	logic sync;
	logic last;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			meta <= 1'b0;
			sync <= 1'b0;
			last <= 1'b0;
		end else begin
			meta <= pin_i;
			sync <= meta;
			last <= sync;
		end
	end

	assign level_o = sync;
	assign rise_o  = sync & ~last;
endmodule
`default_nettype wire

/* hw/etc_exp_conv.sv */
// absolute-to-raw exposure conversion by sequential division with rounding
`timescale 1ns/1ns
`default_nettype none
module etc_exp_conv import etc_pkg::*; (
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic        start_i,
	input  wire logic [31:0] abs_i,
	input  wire logic [23:0] base_i,
	output logic             busy_o,
	output logic             done_o,
	output logic [11:0]      raw_o
);
	// restoring divider, 32 steps; base of zero is treated as one
	logic [31:0] quot;
	logic [32:0] rem;
	logic [5:0]  step;
	logic [23:0] div;
	wire  [32:0] shifted = {rem[31:0], quot[31]};
	wire         fits    = shifted >= {9'h000, div};
	wire  [32:0] rem_nx  = fits ? shifted - {9'h000, div} : shifted;
	wire  [31:0] q_nx    = {quot[30:0], fits};
	// round to nearest: remainder doubled against divisor
	wire         up      = {rem_nx[31:0], 1'b0} >= {9'h000, div};
	wire  [31:0] q_rnd   = q_nx + {31'h0, up};
	wire  [31:0] q_clip  = (q_rnd < {20'h0, ETC_RAW_MIN}) ? {20'h0, ETC_RAW_MIN} :
	                       (q_rnd > {20'h0, ETC_RAW_MAX}) ? {20'h0, ETC_RAW_MAX} : q_rnd;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			busy_o <= 1'b0;
			done_o <= 1'b0;
			raw_o  <= ETC_RAW_RST;
			quot   <= 32'h0;
			rem    <= 33'h0;
			step   <= 6'h0;
			div    <= 24'h1;
		end else begin
			done_o <= 1'b0;
			if (start_i) begin
				busy_o <= 1'b1;
				quot   <= abs_i;
				rem    <= 33'h0;
				step   <= 6'h20;
				div    <= (base_i == 24'h0) ? 24'h1 : base_i;
			end else if (busy_o) begin
				quot <= q_nx;
				rem  <= rem_nx;
				step <= step - 6'h1;
				if (step == 6'h1) begin
					busy_o <= 1'b0;
					done_o <= 1'b1;
					raw_o  <= q_clip[11:0];
				end
			end
		end
	end
endmodule
`default_nettype wire

/* verif/etc_props.sv */
// checker: frame phase timing of the exposure trigger control top
`timescale 1ns/1ns
`default_nettype none
module etc_props #(
	parameter int READOUT_CYCLES = 500,
	parameter int XMIT_CYCLES    = 500
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pslverr_o,
	input wire logic exposing_o,
	input wire logic readout_o,
	input wire logic xmit_o,
	input wire logic frame_start_o
);
	// ****************************************
	// phase length counters
	// ****************************************
	logic [31:0] rd_cnt;
	logic [31:0] tx_cnt;
	always_ff @(posedge clk_i) begin
		rd_cnt <= (rst_i || !readout_o) ? 32'h0 : rd_cnt + 32'h1;
		tx_cnt <= (rst_i || !xmit_o) ? 32'h0 : tx_cnt + 32'h1;
	end
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	// past reset keeps a phase cut short by reset from looking like a short phase
	a_fs_single: assert property (frame_start_o |=> !frame_start_o)
		else $error("frame start pulse longer than one cycle");
	a_exp_cause: assert property ($rose(exposing_o) |-> frame_start_o)
		else $error("exposure began without a frame start");
	a_phase_excl: assert property ($onehot0({exposing_o, readout_o, xmit_o}))
		else $error("frame phases overlap");
	a_exp_to_read: assert property ($fell(exposing_o) && !$past(rst_i) |-> readout_o)
		else $error("readout did not follow exposure");
	a_read_len: assert property ($fell(readout_o) && !$past(rst_i) |-> rd_cnt == READOUT_CYCLES)
		else $error("readout length wrong");
	a_read_to_xmit: assert property ($fell(readout_o) && !$past(rst_i) |-> xmit_o)
		else $error("transmission did not follow readout");
	a_xmit_len: assert property ($fell(xmit_o) && !$past(rst_i) |-> tx_cnt == XMIT_CYCLES)
		else $error("transmission length wrong");
	a_rst_idle: assert property ($past(rst_i) |-> !exposing_o && !frame_start_o ##1 !frame_start_o)
		else $error("frame activity right after reset");
	c_frame: cover property (frame_start_o);
	c_readout: cover property ($rose(readout_o));
	c_slverr: cover property (psel_i && penable_i && pslverr_o);
endmodule
bind etc_top etc_props #(.READOUT_CYCLES(READOUT_CYCLES), .XMIT_CYCLES(XMIT_CYCLES)) etc_props_inst (
	.clk_i(clk_i), .rst_i(rst_i), .psel_i(psel_i), .penable_i(penable_i), .pslverr_o(pslverr_o),
	.exposing_o(exposing_o), .readout_o(readout_o), .xmit_o(xmit_o), .frame_start_o(frame_start_o));
`default_nettype wire

/* verif/etc_trig_src.sv */
// external trigger source model driving input line one
`timescale 1ns/1ns
`default_nettype none
module etc_trig_src (
	input  wire logic clk_i,
	input  wire logic fire_i,
	output logic      line_o
);
	logic [3:0] hold = 4'h0;
	// each request gives one rising edge, held high for eight cycles
	always_ff @(posedge clk_i) begin
		if (fire_i) begin
			hold <= 4'h8;
		end else if (hold != 4'h0) begin
			hold <= hold - 4'h1;
		end
	end
	assign line_o = (hold != 4'h0);
endmodule
`default_nettype wire

/* verif/tb_top.sv */
// testbench: registers, exposure conversion, triggered and free-run frames
`timescale 1ns/1ns
`default_nettype none
module tb_top import etc_pkg::*;;
	logic clk_i, rst_i, psel, pen, pwr, fire, prdy, perr, rerr, line1, expo, rdo, xmo, fso;
	logic [7:0] pa;
	logic [31:0] pwd, prd, rdat;
	int failures, samples_checked, cyc, fs_n, fs_last, fs_prev, er, em, a, b, r, n0;
	logic [7:0] ra[5] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10};
	logic [31:0] rv[5] = '{32'h0, 32'h7D0, 32'h64, 32'h14, 32'h3E8};
	int ca[3] = '{3, 5, 9000};
	int cb[3] = '{7, 2, 1};
	etc_top #(.READOUT_CYCLES(4), .XMIT_CYCLES(4)) etc_top_inst (.clk_i(clk_i), .rst_i(rst_i),
		.psel_i(psel), .penable_i(pen), .pwrite_i(pwr), .paddr_i(pa), .pwdata_i(pwd),
		.prdata_o(prd), .pready_o(prdy), .pslverr_o(perr), .line1_i(line1), .exposing_o(expo),
		.readout_o(rdo), .xmit_o(xmo), .frame_start_o(fso));
	etc_trig_src etc_trig_src_inst (.clk_i(clk_i), .fire_i(fire), .line_o(line1));
	initial begin
		clk_i = 0;
		forever #50 clk_i = ~clk_i;
	end
	// ****************************************
	// helpers
	// ****************************************
	task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk_i);
		psel <= 1; pen <= 0; pwr <= w; pa <= ad; pwd <= d;
		@(posedge clk_i);
		pen <= 1;
		@(posedge clk_i);
		while (prdy !== 1'b1 && n < 200) begin
			@(posedge clk_i);
			n++;
		end
		if (n >= 200)
			failures++;
		rdat = prd;
		rerr = perr;
		psel <= 0; pen <= 0;
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		samples_checked++;
		if (g !== e) begin
			failures++;
			$display("mismatch t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task automatic pulse();
		@(posedge clk_i);
		fire <= 1;
		@(posedge clk_i);
		fire <= 0;
	endtask
	// nearest multiple, half rounds up, then clamped to the raw range
	function automatic logic [31:0] exp_raw(int aa, int bb);
		int q;
		q = (2 * aa + bb) / (2 * bb);
		return (q < 1) ? 1 : (q > 4095) ? 4095 : q;
	endfunction
	function automatic logic [31:0] in_span(int d);
		return (d >= 28 && d <= 32);
	endfunction
	task end_of_test;
		$display("checked %0d failures %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	always @(posedge clk_i) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			failures++;
			end_of_test();
		end
		if (fso === 1'b1) begin
			fs_n <= fs_n + 1; fs_prev <= fs_last; fs_last <= cyc;
		end
		if (expo === 1'b1) er <= er + 1;
		else begin
			if (er != 0) em <= er;
			er <= 0;
		end
	end
	initial begin
		rst_i = 1; psel = 0; pen = 0; pwr = 0; pa = 0; pwd = 0; fire = 0;
		failures = 0; samples_checked = 0; cyc = 0; fs_n = 0; fs_last = 0; fs_prev = 0; er = 0;
		void'($urandom(67));
		repeat (3) @(posedge clk_i);
		rst_i <= 0;
		for (int i = 0; i < 5; i++) begin
			apb(0, ra[i], 0);
			chk(rdat, rv[i]);
		end
		apb(0, 8'h1C, 0);
		chk({31'h0, rerr}, 32'h1);
		$display("test reset done");
		for (int i = 0; i < 10; i++) begin
			b = (i < 3) ? cb[i] : 1 + $urandom % 9;
			a = (i < 3) ? ca[i] : 1 + $urandom % 300;
			apb(1, 8'h0C, b);
			apb(1, 8'h04, a);
			apb(0, 8'h08, 0);
			chk(rdat, exp_raw(a, b));
			apb(0, 8'h04, 0);
			chk(rdat, exp_raw(a, b) * b);
		end
		for (int i = 0; i < 4; i++) begin
			r = (i == 0) ? 0 : $urandom % 4096;
			apb(1, 8'h08, r);
			apb(0, 8'h04, 0);
			chk(rdat, ((r == 0) ? 1 : r) * b);
		end
		$display("test conversion done");
		apb(1, 8'h0C, 1);
		apb(1, 8'h08, 2);
		apb(1, 8'h00, 32'h0E);
		n0 = fs_n;
		pulse();
		repeat (15) @(posedge clk_i);
		pulse();
		repeat (60) @(posedge clk_i);
		chk(fs_n - n0, 1);
		chk(em, 20);
		pulse();
		repeat (60) @(posedge clk_i);
		chk(fs_n - n0, 2);
		apb(0, 8'h18, 0);
		chk(rdat, fs_n);
		apb(0, 8'h14, 0);
		chk(rdat, 32'h1);
		$display("test triggered done");
		apb(1, 8'h00, 0);
		apb(1, 8'h10, 10);
		apb(1, 8'h00, 32'h13);
		repeat (250) @(posedge clk_i);
		chk(fs_last - fs_prev, 100);
		apb(1, 8'h10, 1);
		repeat (100) @(posedge clk_i);
		chk(in_span(fs_last - fs_prev), 1);
		apb(1, 8'h00, 32'h03);
		repeat (100) @(posedge clk_i);
		chk(in_span(fs_last - fs_prev), 1);
		$display("test free run done");
		end_of_test();
	end
endmodule
`default_nettype wire
